/* hdl/eds_cfg.svh */
/*
 * Constants of the exception dispatch sequencer: register offsets, vector
 * offsets, field positions and widths.
 * Assumes it is included by its bare name from the package and the design.
 */
`ifndef EDS_CFG_SVH
`define EDS_CFG_SVH

// ============================================================
// register map (byte addresses)
`define EDS_OFS_VTB        8'h00
`define EDS_OFS_CTRL       8'h04
`define EDS_OFS_STATUS     8'h08
`define EDS_OFS_HVEC       8'h0C
`define EDS_OFS_HPC        8'h10
`define EDS_OFS_SAVED_PSL  8'h14
`define EDS_OFS_SAVED_PC   8'h18
`define EDS_OFS_NPARAM     8'h1C

// ============================================================
// vector offsets within the table page
`define EDS_VEC_MCHECK     9'h004
`define EDS_VEC_RSVD_INSN  9'h010
`define EDS_VEC_CUST_INSN  9'h014
`define EDS_VEC_RSVD_OPND  9'h018
`define EDS_VEC_RSVD_MODE  9'h01C
`define EDS_VEC_ACCESS     9'h020
`define EDS_VEC_XLATE      9'h024
`define EDS_VEC_TRACE      9'h028
`define EDS_VEC_BPT        9'h02C
`define EDS_VEC_ARITH      9'h034
`define EDS_VEC_CHM_BASE   9'h040
`define EDS_VEC_SWI_BASE   9'h080
`define EDS_VEC_TIMER      9'h0C0
`define EDS_VEC_EMUL       9'h0C8
`define EDS_VEC_EMUL_SUSP  9'h0CC

// ============================================================
// status longword fields and levels, base alignment width, parameter counts
`define EDS_PSL_TP         30
`define EDS_PSL_FPD        27
`define EDS_PSL_T          4
`define EDS_PSL_IS         26
`define EDS_PSL_IPL_LO     16
`define EDS_IPL_EXC_MAX    5'h1F
`define EDS_IPL_TIMER      5'h16
`define EDS_VTB_MBZ_W      9
`define EDS_NP_ARITH       4'h1
`define EDS_NP_CHM         4'h1
`define EDS_NP_ACCESS      4'h2
`define EDS_NP_EMUL        4'hA
`define EDS_NP_MCHECK      4'h0

`endif

/* hdl/eds_pkg.sv */
/*
 * Types of the exception dispatch sequencer.
 * Assumes eds_cfg.svh is on the include path.
 */
`include "eds_cfg.svh"
package eds_pkg;
  // ============================================================
  // boundary sequence states
  typedef enum logic [3:0] {
    EDS_IDLE,
    EDS_PRE_INT,
    EDS_TRACE_CHK,
    EDS_POST_INT,
    EDS_START,
    EDS_EXEC,
    EDS_END_CHK,
    EDS_FETCH_REQ,
    EDS_FETCH_WAIT,
    EDS_DISPATCH
  } eds_state_e;

  // fault classes reported by the execution unit
  typedef enum logic [3:0] {
    EDS_F_NONE, EDS_F_RSVD_INSN, EDS_F_CUST_INSN, EDS_F_RSVD_OPND,
    EDS_F_RSVD_MODE, EDS_F_ACCESS, EDS_F_XLATE, EDS_F_BPT,
    EDS_F_EMUL_SUSP, EDS_F_MCHECK
  } eds_fault_e;

  // trap classes at instruction end
  typedef enum logic [2:0] {
    EDS_T_NONE, EDS_T_CHM, EDS_T_EMUL, EDS_T_MCHECK
  } eds_trap_e;

  // execution unit report at instruction end
  typedef struct packed {
    logic       done;
    eds_fault_e fault;
    logic       partial;
    eds_trap_e  trap;
    logic [1:0] chm_mode;
    logic       arith;
  } eds_xu_s;

  // dispatch outcome towards the execution unit
  typedef struct packed {
    logic [31:0] handler_pc;
    logic [31:0] saved_psl;
    logic [31:0] saved_pc;
    logic [3:0]  nparam;
    logic [1:0]  code;
    logic        raise_ipl;
  } eds_disp_s;

  // whole state of the sequencer
  typedef struct packed {
    eds_state_e  st;
    logic [31:0] vtb;
    logic [31:0] processor_status_longword;
    logic [31:0] pc;
    logic [31:0] opc_pc;
    logic        t_at_start;
    logic [8:0]  vofs;
    logic [3:0]  np;
    logic        is_int;
    logic        trap_pend;
    logic [8:0]  trap_vofs;
    logic [3:0]  trap_np;
    logic        ctrl_go;
    eds_disp_s   disp;
    logic        disp_vld;
    logic [31:0] hvec;
    logic        hsel_d;
    logic        hwr_d;
    logic [7:0]  haddr_d;
    logic [31:0] hrdata;
  } eds_state_s;
endpackage : eds_pkg

/* hdl/eds_sequencer.sv */
/*
 * Between-instruction event sequencer: trace, faults, traps, interrupts,
 * console halt and vector-table dispatch, with an AHB-Lite register slave.
 * Assumes a single execution unit that holds its request until answered
 * and a memory port that returns the vector longword some cycles later.
 */
`timescale 1ns/1ns
`include "eds_cfg.svh"
module eds_sequencer (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             xu_boundary,
  input  wire logic [31:0]      xu_next_pc,
  input  wire logic [31:0]      xu_psl,
  input  wire eds_pkg::eds_xu_s xu_report,
  input  wire logic             int_req,
  input  wire logic [4:0]       int_level,
  input  wire logic             int_is_timer,
  input  wire logic             halt_req,
  output logic                  xu_start,
  output logic                  xu_undo_regs,
  output logic                  halted,
  output logic      [31:0]      vec_addr,
  output logic                  vec_req,
  input  wire logic             vec_ack,
  input  wire logic [31:0]      vec_data,
  output logic                  disp_valid,
  output eds_pkg::eds_disp_s    disp_out
);
  import eds_pkg::*;

  eds_state_s r;
  eds_state_s n;
  logic       int_take;
  logic       wr_go;

  // ============================================================
  // helpers
  function automatic logic [8:0] fault_vofs(input eds_fault_e f);
    case (f)
      EDS_F_RSVD_INSN: fault_vofs = `EDS_VEC_RSVD_INSN;
      EDS_F_CUST_INSN: fault_vofs = `EDS_VEC_CUST_INSN;
      EDS_F_RSVD_OPND: fault_vofs = `EDS_VEC_RSVD_OPND;
      EDS_F_RSVD_MODE: fault_vofs = `EDS_VEC_RSVD_MODE;
      EDS_F_ACCESS:    fault_vofs = `EDS_VEC_ACCESS;
      EDS_F_XLATE:     fault_vofs = `EDS_VEC_XLATE;
      EDS_F_BPT:       fault_vofs = `EDS_VEC_BPT;
      EDS_F_EMUL_SUSP: fault_vofs = `EDS_VEC_EMUL_SUSP;
      EDS_F_MCHECK:    fault_vofs = `EDS_VEC_MCHECK;
      default:         fault_vofs = `EDS_VEC_RSVD_INSN;
    endcase
  endfunction : fault_vofs

  function automatic logic [3:0] fault_np(input eds_fault_e f);
    case (f)
      EDS_F_ACCESS, EDS_F_XLATE: fault_np = `EDS_NP_ACCESS;
      EDS_F_MCHECK:              fault_np = `EDS_NP_MCHECK;
      default:                   fault_np = 4'h0;
    endcase
  endfunction : fault_np

  // interrupt vector: software levels use level*4 above 80, timer at C0
  function automatic logic [8:0] int_vofs(input logic tmr, input logic [4:0] lvl);
    if (tmr) begin
      int_vofs = `EDS_VEC_TIMER;
    end else begin
      int_vofs = `EDS_VEC_SWI_BASE + {2'b00, lvl[3:0], 2'b00};
    end
  endfunction : int_vofs

  // interrupts only above current level unless halt_req is set; timer arrives at its fixed level
  always_comb begin
    logic [4:0] lvl;
    lvl = int_is_timer ? `EDS_IPL_TIMER : int_level;
    int_take = (int_req && lvl > r.processor_status_longword[`EDS_PSL_IPL_LO +: 5] &&
                (int_is_timer || (lvl != 5'h00 && lvl < 5'h10))) || halt_req;
  end

  assign wr_go = r.hsel_d && r.hwr_d;

  // ============================================================
  // next state
  always_comb begin
    n = r;
    n.disp_vld = 1'b0;
    n.hsel_d = hsel && hready && htrans[1];
    n.hwr_d = hwrite;
    n.haddr_d = haddr[7:0];
    if (wr_go) begin
      case (r.haddr_d)
        `EDS_OFS_VTB:  n.vtb = {hwdata[31:`EDS_VTB_MBZ_W], {`EDS_VTB_MBZ_W{1'b0}}};
        `EDS_OFS_CTRL: n.ctrl_go = hwdata[0];
        default: ;
      endcase
    end
    // read data is loaded at the address phase so that it stands through
    // the data phase; base and go are forwarded from a write in that phase
    if (n.hsel_d && !hwrite) begin
      case (haddr[7:0])
        `EDS_OFS_VTB:       n.hrdata = n.vtb;
        `EDS_OFS_CTRL:      n.hrdata = {31'h0, n.ctrl_go};
        `EDS_OFS_STATUS:    n.hrdata = {27'h0, r.trap_pend, r.st};
        `EDS_OFS_HVEC:      n.hrdata = r.hvec;
        `EDS_OFS_HPC:       n.hrdata = r.disp.handler_pc;
        `EDS_OFS_SAVED_PSL: n.hrdata = r.disp.saved_psl;
        `EDS_OFS_SAVED_PC:  n.hrdata = r.disp.saved_pc;
        `EDS_OFS_NPARAM:    n.hrdata = {28'h0, r.disp.nparam};
        default:            n.hrdata = 32'h0000_0000;
      endcase
    end
    case (r.st)
      EDS_IDLE: begin
        if (r.ctrl_go) begin
          n.st = EDS_START;
        end
      end
      EDS_PRE_INT: begin
        // interrupt before the trace check; pending bit saved as is
        if (int_take) begin
          n.is_int = 1'b1;
          n.vofs = int_vofs(int_is_timer, int_level);
          n.np = 4'h0;
          n.st = EDS_FETCH_REQ;
        end else begin
          n.st = EDS_TRACE_CHK;
        end
      end
      EDS_TRACE_CHK: begin
        if (r.processor_status_longword[`EDS_PSL_TP]) begin
          n.processor_status_longword[`EDS_PSL_TP] = 1'b0;
          n.vofs = `EDS_VEC_TRACE;
          n.np = 4'h0;
          n.is_int = 1'b0;
          n.st = EDS_FETCH_REQ;
        end else begin
          n.st = EDS_POST_INT;
        end
      end
      EDS_POST_INT: begin
        if (int_take) begin
          n.is_int = 1'b1;
          n.vofs = int_vofs(int_is_timer, int_level);
          n.np = 4'h0;
          n.st = EDS_FETCH_REQ;
        end else begin
          n.st = EDS_START;
        end
      end
      EDS_START: begin
        n.processor_status_longword[`EDS_PSL_TP] = r.processor_status_longword[`EDS_PSL_T];
        n.t_at_start = r.processor_status_longword[`EDS_PSL_T];
        n.opc_pc = r.pc;
        n.st = EDS_EXEC;
      end
      EDS_EXEC: begin
        // an interrupt aborts the instruction here only while fpd is clear; faults are judged in EDS_END_CHK
        if (xu_boundary && xu_report.done) begin
          n.st = EDS_END_CHK;
        end else if (int_take && !r.processor_status_longword[`EDS_PSL_FPD]) begin
          n.pc = r.opc_pc;
          n.processor_status_longword[`EDS_PSL_TP] = 1'b0;
          n.is_int = 1'b1;
          n.vofs = int_vofs(int_is_timer, int_level);
          n.np = 4'h0;
          n.st = EDS_FETCH_REQ;
        end
      end
      EDS_END_CHK: begin
        n.processor_status_longword = xu_psl;
        if (xu_report.fault != EDS_F_NONE) begin
          n.pc = r.opc_pc;
          n.processor_status_longword[`EDS_PSL_FPD] = xu_report.partial ||
                                (xu_report.fault == EDS_F_EMUL_SUSP);
          n.processor_status_longword[`EDS_PSL_TP] = 1'b0;
          n.vofs = fault_vofs(xu_report.fault);
          n.np = fault_np(xu_report.fault);
          n.is_int = 1'b0;
          n.st = EDS_FETCH_REQ;
        end else begin
          n.pc = xu_next_pc;
          n.processor_status_longword[`EDS_PSL_TP] = r.t_at_start;
          n.is_int = 1'b0;
          n.trap_pend = 1'b1;
          case (xu_report.trap)
            EDS_T_CHM: begin
              n.vofs = `EDS_VEC_CHM_BASE + {5'h00, xu_report.chm_mode, 2'b00};
              n.np = `EDS_NP_CHM;
            end
            EDS_T_EMUL: begin
              n.vofs = `EDS_VEC_EMUL;
              n.np = `EDS_NP_EMUL;
              n.processor_status_longword[`EDS_PSL_FPD] = 1'b0;
            end
            EDS_T_MCHECK: begin
              n.vofs = `EDS_VEC_MCHECK;
              n.np = `EDS_NP_MCHECK;
            end
            default: begin
              n.trap_pend = xu_report.arith;
              n.vofs = `EDS_VEC_ARITH;
              n.np = `EDS_NP_ARITH;
            end
          endcase
          n.st = n.trap_pend ? EDS_FETCH_REQ : EDS_PRE_INT;
        end
      end
      EDS_FETCH_REQ: begin
        n.st = EDS_FETCH_WAIT;
      end
      EDS_FETCH_WAIT: begin
        if (vec_ack) begin
          n.hvec = vec_data;
          n.st = EDS_DISPATCH;
        end
      end
      EDS_DISPATCH: begin
        // state saved is the one in force now: for a trap followed by an
        // interrupt, the second pass saves the trap handler's pc and psl when the trap vector's code is not 01, which raises ipl to 1F
        n.disp.saved_pc = r.pc;
        n.disp.saved_psl = r.processor_status_longword;
        n.disp.nparam = r.np;
        n.disp.code = r.hvec[1:0];
        n.disp.raise_ipl = (r.hvec[1:0] == 2'b01) && !r.is_int;
        n.disp.handler_pc = {r.hvec[31:2], 2'b00};
        n.disp_vld = 1'b1;
        n.pc = {r.hvec[31:2], 2'b00};
        n.processor_status_longword[`EDS_PSL_TP] = 1'b0;
        n.processor_status_longword[`EDS_PSL_T] = 1'b0;
        n.processor_status_longword[`EDS_PSL_FPD] = 1'b0;
        if (r.hvec[1:0] == 2'b01) begin
          n.processor_status_longword[`EDS_PSL_IS] = 1'b1;
          if (!r.is_int) begin
            n.processor_status_longword[`EDS_PSL_IPL_LO +: 5] = `EDS_IPL_EXC_MAX;
          end
        end
        if (r.is_int) begin
          n.processor_status_longword[`EDS_PSL_IPL_LO +: 5] = int_is_timer ? `EDS_IPL_TIMER : int_level;
        end
        n.trap_pend = 1'b0;
        // pending interrupt checked before the handler's first instruction
        n.st = EDS_PRE_INT;
        if (halt_req) begin
          n.st = EDS_IDLE;
          n.ctrl_go = 1'b0;
        end
      end
      default: n.st = EDS_IDLE;
    endcase
  end

  // ============================================================
  // state register; table base deliberately left without reset value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.st <= EDS_IDLE;
      r.processor_status_longword <= 32'h0000_0000;
      r.pc <= 32'h0000_0000;
      r.opc_pc <= 32'h0000_0000;
      r.t_at_start <= 1'b0;
      r.vofs <= 9'h000;
      r.np <= 4'h0;
      r.is_int <= 1'b0;
      r.trap_pend <= 1'b0;
      r.trap_vofs <= 9'h000;
      r.trap_np <= 4'h0;
      r.ctrl_go <= 1'b0;
      r.disp <= '0;
      r.disp_vld <= 1'b0;
      r.hvec <= 32'h0000_0000;
      r.hsel_d <= 1'b0;
      r.hwr_d <= 1'b0;
      r.haddr_d <= 8'h00;
      r.hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      r.st <= n.st;
      r.processor_status_longword <= n.processor_status_longword;
      r.pc <= n.pc;
      r.opc_pc <= n.opc_pc;
      r.t_at_start <= n.t_at_start;
      r.vofs <= n.vofs;
      r.np <= n.np;
      r.is_int <= n.is_int;
      r.trap_pend <= n.trap_pend;
      r.trap_vofs <= n.trap_vofs;
      r.trap_np <= n.trap_np;
      r.ctrl_go <= n.ctrl_go;
      r.disp <= n.disp;
      r.disp_vld <= n.disp_vld;
      r.hvec <= n.hvec;
      r.hsel_d <= n.hsel_d;
      r.hwr_d <= n.hwr_d;
      r.haddr_d <= n.haddr_d;
      r.hrdata <= n.hrdata;
      r.vtb <= n.vtb;
    end
  end

  // ============================================================
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign xu_start = (r.st == EDS_EXEC);
  assign xu_undo_regs = (r.st == EDS_END_CHK) && (xu_report.fault != EDS_F_NONE) &&
                        !xu_report.partial;
  assign halted = (r.st == EDS_IDLE);
  assign vec_addr = r.vtb + {23'h0, r.vofs};
  assign vec_req = (r.st == EDS_FETCH_WAIT);
  assign disp_valid = r.disp_vld;
  assign disp_out = r.disp;

  // ============================================================
  // checks
  trace_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == EDS_TRACE_CHK && r.processor_status_longword[`EDS_PSL_TP] && clk_en) |=>
      (r.vofs == `EDS_VEC_TRACE && !r.processor_status_longword[`EDS_PSL_TP]))
    else $error("trace fault not first");
  tp_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == EDS_START && clk_en) |=> (r.processor_status_longword[`EDS_PSL_TP] == $past(r.processor_status_longword[`EDS_PSL_T])))
    else $error("pending not copied");
  base_align_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_go && r.haddr_d == `EDS_OFS_VTB && clk_en) |=> (r.vtb[8:0] == 9'h000))
    else $error("base not aligned");
  handler_pc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    disp_valid |-> (disp_out.handler_pc[1:0] == 2'b00 &&
                    disp_out.handler_pc[31:2] == $past(r.hvec[31:2])))
    else $error("handler pc wrong");
  vec_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_req |-> (vec_addr[31:9] == r.vtb[31:9] && vec_addr[8:0] == r.vofs &&
                 r.vofs[1:0] == 2'b00))
    else $error("vector address wrong");
  arith_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == EDS_END_CHK && clk_en && xu_report.fault != EDS_F_NONE) |=>
      (r.vofs != `EDS_VEC_ARITH))
    else $error("arith trap with fault");
  fault_rewind_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == EDS_END_CHK && clk_en && xu_report.fault != EDS_F_NONE) |=>
      (r.pc == $past(r.opc_pc) && !r.processor_status_longword[`EDS_PSL_TP]))
    else $error("fault did not rewind");
  access_two_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == EDS_FETCH_REQ && (r.vofs == `EDS_VEC_ACCESS || r.vofs == `EDS_VEC_XLATE))
      |-> (r.np == `EDS_NP_ACCESS))
    else $error("access fault params");
endmodule : eds_sequencer

/* testbench/eds_far_model.sv */
/*
 * Partner model: the execution unit that runs instructions between
 * boundaries, and the memory that holds the vector table page.
 * Assumes the sequencer holds vec_req until it samples vec_ack.
 */
`timescale 1ns/1ns
module eds_far_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        xu_start,
  input  wire logic        vec_req,
  input  wire logic [31:0] vec_addr,
  output logic             xu_boundary,
  output logic             vec_ack,
  output logic      [31:0] vec_data
);
  logic [1:0] run_cnt;
  logic [1:0] wait_cnt;
  logic       slow;
  logic [1:0] code;

  // ============================================================
  // execution unit: each instruction ends on its third cycle;
  // the boundary stands one cycle past the start window so the
  // report is still valid while it is checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_cnt     <= 2'h0;
      xu_boundary <= 1'h0;
    end else if (xu_start) begin
      run_cnt     <= (run_cnt == 2'h3) ? run_cnt : run_cnt + 2'h1;
      xu_boundary <= (run_cnt != 2'h0);
    end else begin
      run_cnt     <= 2'h0;
      xu_boundary <= 1'h0;
    end
  end

  // ============================================================
  // vector memory: alternates prompt and slow answers; change-mode and
  // emulation vectors carry code 0, the others code 1
  assign code = (vec_addr[8:4] == 5'h04 || vec_addr[8:3] == 6'h19) ? 2'h0 : 2'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 2'h0;
      slow     <= 1'h0;
      vec_ack  <= 1'h0;
      vec_data <= 32'h0000_0000;
    end else if (vec_req && !vec_ack && wait_cnt == (slow ? 2'h3 : 2'h0)) begin
      vec_ack  <= 1'h1;
      vec_data <= {2'h1, 19'h0_0000, vec_addr[8:0], code};
      wait_cnt <= 2'h0;
      slow     <= !slow;
    end else begin
      vec_ack  <= 1'h0;
      // released bus: never leave the last word standing
      vec_data <= ~vec_data;
      wait_cnt <= (vec_req && !vec_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : eds_far_model

/* testbench/testbench.sv */
/*
 * Self-checking bench of the exception dispatch sequencer.
 * Assumes eds_cfg.svh on the include path and the partner model beside it.
 */
`timescale 1ns/1ns
`include "eds_cfg.svh"
module testbench;
  import eds_pkg::*;
  typedef struct packed {
    eds_fault_e f;
    eds_trap_e  t;
    logic [1:0] m;
    logic       ar;
    logic       in;
    logic [4:0] lv;
    logic       tm;
    logic [8:0] ofs;
    logic [3:0] np;
  } eds_row_s;

  logic        hclk = 1'h0, hresetn = 1'h0, clk_en = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, xu_next_pc = 32'h0000_1000;
  logic [31:0] xu_psl = 32'h0, vec_addr, vec_data, rd, vtb = 32'h0001_2200;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [4:0]  int_level = 5'h0;
  logic        hreadyout, hresp, xu_boundary, int_req = 1'h0, int_is_timer = 1'h0;
  logic        halt_req = 1'h0, xu_start, xu_undo_regs, halted, vec_req, vec_ack;
  logic        disp_valid, undo_seen = 1'h0;
  eds_xu_s     xu_report = '{1'h1, EDS_F_NONE, 1'h0, EDS_T_NONE, 2'h0, 1'h0};
  eds_disp_s   disp_out;
  eds_row_s    rows [21];
  int          n_mismatch = 0, n_tests = 0;

  always #50 hclk = ~hclk;
  always @(posedge hclk) if (xu_undo_regs === 1'h1) undo_seen <= 1'h1;

  eds_sequencer uut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .xu_boundary(xu_boundary), .xu_next_pc(xu_next_pc), .xu_psl(xu_psl),
    .xu_report(xu_report), .int_req(int_req), .int_level(int_level),
    .int_is_timer(int_is_timer), .halt_req(halt_req), .xu_start(xu_start),
    .xu_undo_regs(xu_undo_regs), .halted(halted), .vec_addr(vec_addr),
    .vec_req(vec_req), .vec_ack(vec_ack), .vec_data(vec_data),
    .disp_valid(disp_valid), .disp_out(disp_out));
  eds_far_model far (.hclk(hclk), .hresetn(hresetn), .xu_start(xu_start),
    .vec_req(vec_req), .vec_addr(vec_addr), .xu_boundary(xu_boundary),
    .vec_ack(vec_ack), .vec_data(vec_data));

  // ============================================================
  // shared tasks
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // bounded wait, sampled mid-cycle where outputs have settled
  task automatic wt(ref logic s);
    int i;
    for (i = 0; i < 300 && s !== 1'h1; i++) @(negedge hclk);
    if (s !== 1'h1) begin
      chk("wait", 32'(s), 32'h1);
      conclude();
    end
  endtask : wt

  task automatic rdy();
    int i;
    @(posedge hclk);
    for (i = 0; i < 20 && hreadyout !== 1'h1; i++) @(posedge hclk);
    if (hreadyout !== 1'h1) begin
      chk("hreadyout", 32'(hreadyout), 32'h1);
      conclude();
    end
  endtask : rdy

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    rdy();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask : ahb

  // one dispatch: vector address, handler, parameters, code
  task automatic ev(input logic [8:0] ofs, input logic [3:0] np, input logic exc,
                    input logic clr);
    logic [31:0] va;
    logic [1:0]  cd;
    wt(vec_req);
    va = vec_addr;
    cd = (ofs[8:4] == 5'h04 || ofs[8:3] == 6'h19) ? 2'h0 : 2'h1;
    @(posedge hclk);
    xu_report <= '{1'h1, EDS_F_NONE, 1'h0, EDS_T_NONE, 2'h0, 1'h0};
    xu_psl    <= 32'h0;
    if (clr) int_req <= 1'h0;
    wt(disp_valid);
    chk("vec_addr", va, vtb + {23'h0, ofs});
    chk("handler_pc", disp_out.handler_pc, {2'h1, 19'h0, ofs, 2'h0});
    chk("nparam", {28'h0, disp_out.nparam}, {28'h0, np});
    chk("code", {30'h0, disp_out.code}, {30'h0, cd});
    chk("raise_ipl", 32'(disp_out.raise_ipl), 32'(exc && cd == 2'h1));
  endtask : ev

  // ============================================================
  // main sequence
  initial begin
    rows = '{
      '{EDS_F_RSVD_INSN, EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h010, 4'h0},
      '{EDS_F_CUST_INSN, EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h014, 4'h0},
      '{EDS_F_RSVD_OPND, EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h018, 4'h0},
      '{EDS_F_RSVD_MODE, EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h01C, 4'h0},
      '{EDS_F_ACCESS,    EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h020, 4'h2},
      '{EDS_F_XLATE,     EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h024, 4'h2},
      '{EDS_F_BPT,       EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h02C, 4'h0},
      '{EDS_F_EMUL_SUSP, EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h0CC, 4'h0},
      '{EDS_F_MCHECK,    EDS_T_NONE, 2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h004, 4'h0},
      '{EDS_F_NONE, EDS_T_CHM,    2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h040, 4'h1},
      '{EDS_F_NONE, EDS_T_CHM,    2'h1, 1'h0, 1'h0, 5'h0, 1'h0, 9'h044, 4'h1},
      '{EDS_F_NONE, EDS_T_CHM,    2'h2, 1'h0, 1'h0, 5'h0, 1'h0, 9'h048, 4'h1},
      '{EDS_F_NONE, EDS_T_CHM,    2'h3, 1'h0, 1'h0, 5'h0, 1'h0, 9'h04C, 4'h1},
      '{EDS_F_NONE, EDS_T_EMUL,   2'h0, 1'h0, 1'h0, 5'h0, 1'h0, 9'h0C8, 4'hA},
      '{EDS_F_NONE, EDS_T_NONE,   2'h0, 1'h1, 1'h0, 5'h0, 1'h0, 9'h034, 4'h1},
      '{EDS_F_ACCESS, EDS_T_NONE, 2'h0, 1'h1, 1'h0, 5'h0, 1'h0, 9'h020, 4'h2},
      '{EDS_F_NONE, EDS_T_CHM,    2'h0, 1'h1, 1'h0, 5'h0, 1'h0, 9'h040, 4'h1},
      '{EDS_F_NONE, EDS_T_NONE,   2'h0, 1'h0, 1'h1, 5'h01, 1'h0, 9'h084, 4'h0},
      '{EDS_F_NONE, EDS_T_NONE,   2'h0, 1'h0, 1'h1, 5'h02, 1'h0, 9'h088, 4'h0},
      '{EDS_F_NONE, EDS_T_NONE,   2'h0, 1'h0, 1'h1, 5'h0F, 1'h0, 9'h0BC, 4'h0},
      '{EDS_F_NONE, EDS_T_NONE,   2'h0, 1'h0, 1'h1, 5'h16, 1'h1, 9'h0C0, 4'h0}};
    repeat (3) @(negedge hclk);
    chk("halted_rst", 32'(halted), 32'h1);
    chk("hreadyout_rst", 32'(hreadyout), 32'h1);
    chk("disp_valid_rst", 32'(disp_valid), 32'h0);
    @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h1, 8'h00, 32'h0001_23FF);
    ahb(1'h0, 8'h00, 32'h0);
    chk("table_base", rd, vtb);
    ahb(1'h0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'h1, 8'h04, 32'h0000_0001);
    foreach (rows[k]) begin
      @(posedge hclk);
      xu_report    <= '{1'h1, rows[k].f, 1'h0, rows[k].t, rows[k].m, rows[k].ar};
      int_req      <= rows[k].in;
      int_level    <= rows[k].lv;
      int_is_timer <= rows[k].tm;
      undo_seen    <= 1'h0;
      ev(rows[k].ofs, rows[k].np, !rows[k].in, 1'h1);
      if (rows[k].f inside {EDS_F_RSVD_INSN, EDS_F_RSVD_OPND, EDS_F_ACCESS}) begin
        chk("saved_tp", 32'(disp_out.saved_psl[`EDS_PSL_TP]), 32'h0);
        chk("undo", 32'(undo_seen), 32'h1);
      end
      ahb(1'h0, 8'h1C, 32'h0);
      chk("nparam_reg", rd, {28'h0, rows[k].np});
    end
    // trap and interrupt after one instruction: trap stacked first
    @(posedge hclk);
    xu_report <= '{1'h1, EDS_F_NONE, 1'h0, EDS_T_NONE, 2'h0, 1'h1};
    int_req   <= 1'h1;
    int_level <= 5'h03;
    int_is_timer <= 1'h0;
    ev(9'h034, 4'h1, 1'h1, 1'h0);
    chk("trap_pc", disp_out.saved_pc, 32'h0000_1000);
    ev(9'h08C, 4'h0, 1'h0, 1'h1);
    // trace enable: pending set at end, fault through 28 stacked clear
    @(posedge hclk);
    xu_psl <= 32'h0000_0010;
    ev(9'h028, 4'h0, 1'h1, 1'h0);
    chk("trace_tp", 32'(disp_out.saved_psl[`EDS_PSL_TP]), 32'h0);
    chk("trace_pc", disp_out.saved_pc, 32'h0000_1000);
    repeat (20) @(posedge hclk);
    halt_req <= 1'h1;
    wt(halted);
    @(posedge hclk);
    halt_req <= 1'h0;
    ahb(1'h0, 8'h04, 32'h0);
    chk("go_cleared", rd, 32'h0);
    @(negedge hclk);
    chk("halted", 32'(halted), 32'h1);
    conclude();
  end
endmodule : testbench
